// File: core/dpsm_map.svh
// How it works
// - Control bits: 0 switch on, 1 voltage, 2 quick stop low, 3 run, 7 reset, 8 halt.
// - Word xx110 goes to ready; xx111 goes to switched on.
// - Word 1111 enables operation; 0111 from running returns to switched on.
// - Bit 1 clear disables voltage from any powered state.
// - Quick stop: running goes to quick stop active, ready/switched on to disabled.
// - Fault reset acts only on a rising edge of bit 7.
// - Don't-care bits of each command never affect its decoding.
// - Halt stops motion per stop type while staying in operation enabled.
// - Halt removes power and torque only in open-loop configuration.
// - Fast stop from terminal or assigned bit goes to switched on; halt never.
// - Freewheel stop from terminal or assigned bit goes to switch on disabled.
// - Bits 11 to 15 are assignable per function by a small code.
// - Bit 11 selects reverse direction by default.
// - Status bits 0 to 7 report the state flags, supply and warning.
// - Status bits 9,10,11,14,15 report remote, target, limit, stop key, direction.
// - Masked status 0x40, 0x21, 0x23, 0x27 for the four normal states.
// - Quick stop reads 0x07; fault 0x08 or 0x28; fault reaction sets bits 0-3.
// - Don't-care status bits may read either value.
// - Disable operation: code 0 freewheels at once, code 1 ramps first.
// - Quick stop code 2 ends in disabled; code 6 holds until released.
`ifndef DPSM_MAP_SVH
`define DPSM_MAP_SVH
`define DPSM_CTRL_OFS 12'h000
`define DPSM_STAT_OFS 12'h004
`define DPSM_CFG_OFS 12'h008
`define DPSM_CTRL_RST 16'h0000
`define DPSM_CTRL_WMASK 16'hF98F
`define DPSM_CFG_RST 32'h0001_0020
`define DPSM_STAT_MASK 16'h006F
`define DPSM_ST_SOD 16'h0040
`define DPSM_ST_RDY 16'h0021
`define DPSM_ST_SWON 16'h0023
`define DPSM_ST_OPEN 16'h0027
`define DPSM_ST_QSA 16'h0007
`define DPSM_ST_FLT 16'h0008
`define DPSM_ST_FLTQ 16'h0028
`define DPSM_ST_FRA 16'h000F
`define DPSM_BIT_FRST 7
`define DPSM_BIT_HALT 8
`define DPSM_ASSIGN_BASE 10
`endif

// File: core/dpsm_pkg.sv
package dpsm_pkg;
  typedef enum logic [2:0] {
    ST_NOT_READY, ST_SOD, ST_READY, ST_SWON, ST_OPEN, ST_QSA, ST_FRA, ST_FAULT
  } dpsm_state_t;
  typedef enum logic [1:0] {STOP_FAST, STOP_RAMP, STOP_FREE, STOP_DC} dpsm_stop_t;
  // Configuration register layout, high bits first
  typedef struct packed {
    logic [12:0] rsvd;
    logic [2:0] reverse_direction_assign;
    logic rsvd2;
    logic [2:0] free_assign;
    logic rsvd1;
    logic [2:0] fast_assign;
    logic rsvd0;
    logic [2:0] quick_stop_option_code;
    logic disable_op_option_code;
    logic closed_loop;
    dpsm_stop_t stop_type;
  } dpsm_cfg_t;
  // Pin inputs from the drive power stage and terminals
  typedef struct packed {
    logic fault;
    logic fault_done;
    logic stop_done;
    logic line_ok;
    logic warning;
    logic remote;
    logic target;
    logic limit;
    logic stop_key;
    logic term_fast;
    logic term_free;
  } dpsm_pins_t;
  // Commands to the motor control
  typedef struct packed {
    logic contactor;
    logic power_en;
    logic torque_en;
    logic ramp_stop;
    logic fast_ramp;
    logic freewheel;
    logic dc_inject;
    logic reverse;
  } dpsm_drive_t;
endpackage : dpsm_pkg

// File: core/dpsm_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "dpsm_map.svh"
module dpsm_top (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dpsm_pkg::dpsm_pins_t pins_i,
  output dpsm_pkg::dpsm_drive_t drive_o,
  output dpsm_pkg::dpsm_state_t state_o
);
  // ----------------------------------------
  // Registers and input synchronisers
  // ----------------------------------------
  logic [15:0] ctrl_r;
  dpsm_pkg::dpsm_cfg_t cfg_r;
  dpsm_pkg::dpsm_pins_t sync1_r;
  dpsm_pkg::dpsm_pins_t pin_r;
  dpsm_pkg::dpsm_state_t state_r;
  dpsm_pkg::dpsm_state_t state_nxt;
  logic frst_prev_r;
  logic dis_ramp_r;
  logic flt_after_qs_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  dpsm_pkg::dpsm_drive_t drive_r;
  logic [15:0] stat;

  // Picks an assignable bit 11..15 by code 1..5; other codes mean unused
  function automatic logic sel_bit(input logic [15:0] cw, input logic [2:0] code);
    logic r;
    r = 1'b0;
    if (code >= 3'd1 && code <= 3'd5) begin
      r = cw[`DPSM_ASSIGN_BASE + 32'(code)];
    end
    return r;
  endfunction : sel_bit

  // Pins cross into this clock through two flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= '0;
      pin_r <= '0;
    end else begin
      sync1_r <= pins_i;
      pin_r <= sync1_r;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic apb_acc;
  logic apb_done;
  logic addr_ok;
  assign apb_acc = psel & penable;
  assign apb_done = apb_acc & pready_r;
  assign addr_ok = (paddr == `DPSM_CTRL_OFS) | (paddr == `DPSM_STAT_OFS) |
                   (paddr == `DPSM_CFG_OFS);

  // One wait state; the answer is a single-cycle pready pulse
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= apb_acc & ~pready_r;
      pslverr_r <= apb_acc & ~pready_r & ~addr_ok;
      if (apb_acc && !pready_r && !pwrite) begin
        case (paddr)
          `DPSM_CTRL_OFS: prdata_r <= {16'h0000, ctrl_r};
          `DPSM_STAT_OFS: prdata_r <= {16'h0000, stat};
          `DPSM_CFG_OFS: prdata_r <= cfg_r;
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Writes land on the edge that completes the transfer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `DPSM_CTRL_RST;
      cfg_r <= `DPSM_CFG_RST;
    end else if (apb_done && pwrite) begin
      if (paddr == `DPSM_CTRL_OFS) begin
        ctrl_r <= pwdata[15:0] & `DPSM_CTRL_WMASK;
      end
      if (paddr == `DPSM_CFG_OFS) begin
        cfg_r <= pwdata;
      end
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  // Each decode looks only at the bits its command cares about
  logic c_shutdown;
  logic c_switch_on;
  logic c_enable;
  logic c_disable_op;
  logic c_dis_volt;
  logic c_quick;
  logic c_frst;
  logic halt_req;
  logic fast_req;
  logic free_req;
  assign c_shutdown = ctrl_r[2:0] == 3'b110;
  assign c_switch_on = ctrl_r[2:0] == 3'b111;
  assign c_enable = ctrl_r[3:0] == 4'hF;
  assign c_disable_op = ctrl_r[3:0] == 4'h7;
  assign c_dis_volt = ~ctrl_r[1];
  assign c_quick = ctrl_r[2:1] == 2'b01;
  assign c_frst = ctrl_r[`DPSM_BIT_FRST] & ~frst_prev_r;
  assign halt_req = ctrl_r[`DPSM_BIT_HALT];
  assign fast_req = pin_r.term_fast | sel_bit(ctrl_r, cfg_r.fast_assign);
  assign free_req = pin_r.term_free | sel_bit(ctrl_r, cfg_r.free_assign);

  // Previous fault reset bit for edge detection
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      frst_prev_r <= 1'b0;
    end else begin
      frst_prev_r <= ctrl_r[`DPSM_BIT_FRST];
    end
  end

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  // Fault wins over commands; unmatched words hold the state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dpsm_pkg::ST_NOT_READY: state_nxt = dpsm_pkg::ST_SOD;
      dpsm_pkg::ST_SOD: begin
        if (c_shutdown && !free_req) state_nxt = dpsm_pkg::ST_READY;
      end
      dpsm_pkg::ST_READY: begin
        if (c_dis_volt || c_quick || free_req) begin
          state_nxt = dpsm_pkg::ST_SOD;
        end else if (c_switch_on) begin
          state_nxt = dpsm_pkg::ST_SWON;
        end
      end
      dpsm_pkg::ST_SWON: begin
        if (c_dis_volt || c_quick || free_req) begin
          state_nxt = dpsm_pkg::ST_SOD;
        end else if (c_shutdown) begin
          state_nxt = dpsm_pkg::ST_READY;
        end else if (c_enable && !fast_req) begin
          state_nxt = dpsm_pkg::ST_OPEN;
        end
      end
      dpsm_pkg::ST_OPEN: begin
        if (c_dis_volt || free_req) begin
          state_nxt = dpsm_pkg::ST_SOD;
        end else if (c_quick) begin
          state_nxt = dpsm_pkg::ST_QSA;
        end else if (c_shutdown) begin
          state_nxt = dpsm_pkg::ST_READY;
        end else if (fast_req) begin
          state_nxt = dpsm_pkg::ST_SWON;
        end else if (c_disable_op) begin
          // Ramp option waits for the motor to stop first
          if (!cfg_r.disable_op_option_code || pin_r.stop_done) begin
            state_nxt = dpsm_pkg::ST_SWON;
          end
        end
      end
      dpsm_pkg::ST_QSA: begin
        if (c_dis_volt || free_req || pin_r.stop_key) begin
          state_nxt = dpsm_pkg::ST_SOD;
        end else if (cfg_r.quick_stop_option_code != 3'd6 && pin_r.stop_done) begin
          state_nxt = dpsm_pkg::ST_SOD;
        end
      end
      dpsm_pkg::ST_FRA: begin
        if (pin_r.fault_done) state_nxt = dpsm_pkg::ST_FAULT;
      end
      dpsm_pkg::ST_FAULT: begin
        if (c_frst) state_nxt = dpsm_pkg::ST_SOD;
      end
      default: state_nxt = dpsm_pkg::ST_NOT_READY;
    endcase
    if (pin_r.fault && state_r != dpsm_pkg::ST_FRA && state_r != dpsm_pkg::ST_FAULT &&
        state_r != dpsm_pkg::ST_NOT_READY) begin
      state_nxt = dpsm_pkg::ST_FRA;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= dpsm_pkg::ST_NOT_READY;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Remembers that the fault began in quick stop, for the status word
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flt_after_qs_r <= 1'b0;
    end else if (state_nxt == dpsm_pkg::ST_FRA && state_r != dpsm_pkg::ST_FRA) begin
      flt_after_qs_r <= state_r == dpsm_pkg::ST_QSA;
    end
  end

  // Disable-operation ramp in progress
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dis_ramp_r <= 1'b0;
    end else begin
      dis_ramp_r <= state_nxt == dpsm_pkg::ST_OPEN && c_disable_op &&
                    cfg_r.disable_op_option_code;
    end
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  // Low byte from the state, bits 4 and 7 from the pins; don't-care bits settle to fixed values
  always_comb begin
    stat = 16'h0000;
    case (state_r)
      dpsm_pkg::ST_SOD: stat = `DPSM_ST_SOD;
      dpsm_pkg::ST_READY: stat = `DPSM_ST_RDY;
      dpsm_pkg::ST_SWON: stat = `DPSM_ST_SWON;
      dpsm_pkg::ST_OPEN: stat = `DPSM_ST_OPEN;
      dpsm_pkg::ST_QSA: stat = `DPSM_ST_QSA;
      dpsm_pkg::ST_FRA: stat = `DPSM_ST_FRA;
      dpsm_pkg::ST_FAULT: stat = flt_after_qs_r ? `DPSM_ST_FLTQ : `DPSM_ST_FLT;
      default: stat = 16'h0000;
    endcase
    stat[4] = pin_r.line_ok;
    stat[7] = pin_r.warning;
    stat[9] = pin_r.remote;
    stat[10] = pin_r.target;
    stat[11] = pin_r.limit;
    stat[14] = pin_r.stop_key;
    stat[15] = drive_r.reverse;
  end

  // ----------------------------------------
  // Drive commands
  // ----------------------------------------
  // Halt stops motion inside operation enabled; the stop type picks how
  logic halting;
  assign halting = state_r == dpsm_pkg::ST_OPEN && halt_req;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      drive_r <= '0;
    end else begin
      drive_r.contactor <= state_nxt == dpsm_pkg::ST_SWON ||
                           state_nxt == dpsm_pkg::ST_OPEN || state_nxt == dpsm_pkg::ST_QSA;
      drive_r.power_en <= (state_nxt == dpsm_pkg::ST_OPEN &&
                           !(halting && !cfg_r.closed_loop)) ||
                          state_nxt == dpsm_pkg::ST_QSA;
      drive_r.torque_en <= (state_nxt == dpsm_pkg::ST_OPEN &&
                            !(halting && !cfg_r.closed_loop)) ||
                           state_nxt == dpsm_pkg::ST_QSA;
      drive_r.fast_ramp <= state_nxt == dpsm_pkg::ST_QSA ||
                           (halting && cfg_r.stop_type == dpsm_pkg::STOP_FAST);
      drive_r.ramp_stop <= dis_ramp_r ||
                           (halting && cfg_r.stop_type == dpsm_pkg::STOP_RAMP);
      drive_r.freewheel <= halting && cfg_r.stop_type == dpsm_pkg::STOP_FREE;
      drive_r.dc_inject <= halting && cfg_r.stop_type == dpsm_pkg::STOP_DC;
      drive_r.reverse <= sel_bit(ctrl_r, cfg_r.reverse_direction_assign);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign drive_o = drive_r;
  assign state_o = state_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_init_to_sod: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state_r == dpsm_pkg::ST_NOT_READY |=> state_r == dpsm_pkg::ST_SOD)
    else $error("not ready did not pass to switch on disabled");
  a_status_mask: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state_r == dpsm_pkg::ST_OPEN |-> (stat & `DPSM_STAT_MASK) == `DPSM_ST_OPEN)
    else $error("status does not show operation enabled");
  a_frst_edge: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state_r == dpsm_pkg::ST_FAULT && !pin_r.fault && $rose(ctrl_r[7])
    |=> state_r == dpsm_pkg::ST_SOD)
    else $error("fault reset edge not taken");
  a_frst_level: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state_r == dpsm_pkg::ST_FAULT && $stable(ctrl_r[7]) |=> state_r == dpsm_pkg::ST_FAULT)
    else $error("fault left without reset edge");
  a_dis_volt: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state_r inside {dpsm_pkg::ST_READY, dpsm_pkg::ST_SWON, dpsm_pkg::ST_OPEN} &&
    !ctrl_r[1] && !pin_r.fault |=> state_r == dpsm_pkg::ST_SOD)
    else $error("disable voltage ignored");
  a_quick_open: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state_r == dpsm_pkg::ST_OPEN && ctrl_r[2:1] == 2'b01 && !free_req && !pin_r.fault
    |=> state_r == dpsm_pkg::ST_QSA ##1 drive_r.fast_ramp)
    else $error("quick stop from running not entered");
  a_halt_stays: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state_r == dpsm_pkg::ST_OPEN && ctrl_r[3:0] == 4'hF && !fast_req && !free_req &&
    !pin_r.fault |=> state_r == dpsm_pkg::ST_OPEN)
    else $error("halt or nothing left operation enabled");
  a_halt_open_loop: assert property (@(posedge clk_sys) disable iff (!arst_n)
    halting && !cfg_r.closed_loop && $stable(state_r) |=> !drive_r.power_en)
    else $error("open-loop halt kept power");
  a_apb_answer: assert property (@(posedge clk_sys) disable iff (!arst_n)
    psel && penable && !pready_r |=> pready_r ##1 !pready_r)
    else $error("apb answer not one pulse");
  a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ctrl_r[6:4] == 3'b000 && ctrl_r[10:9] == 2'b00)
    else $error("reserved control bits not zero");
  // Stop requests and the held quick stop
  a_free_sod: assert property (@(posedge clk_sys) disable iff (!arst_n)
    free_req && state_r inside {dpsm_pkg::ST_READY, dpsm_pkg::ST_SWON, dpsm_pkg::ST_OPEN} &&
    !pin_r.fault |=> state_r == dpsm_pkg::ST_SOD)
    else $error("freewheel stop did not disable");
  a_fast_swon: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state_r == dpsm_pkg::ST_OPEN && ctrl_r[2:0] == 3'b111 && fast_req && !free_req &&
    !pin_r.fault |=> state_r == dpsm_pkg::ST_SWON)
    else $error("fast stop did not reach switched on");
  a_qs_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state_r == dpsm_pkg::ST_QSA && cfg_r.quick_stop_option_code == 3'd6 && ctrl_r[1] &&
    !free_req && !pin_r.stop_key && !pin_r.fault |=> state_r == dpsm_pkg::ST_QSA)
    else $error("held quick stop was left");
  a_halt_dc: assert property (@(posedge clk_sys) disable iff (!arst_n)
    halting && cfg_r.stop_type == dpsm_pkg::STOP_DC |=> drive_r.dc_inject)
    else $error("halt with dc stop type did not inject");
endmodule : dpsm_top
`default_nettype wire

// File: sim/dpsm_plc.sv
`timescale 1ns/100ps
`default_nettype none
`include "dpsm_map.svh"
// ----------------------------------------
// Fieldbus master model driving the APB port
// ----------------------------------------
module dpsm_plc (
  input wire logic clk_sys,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Reserved control bits always go out as zero
  localparam logic [31:0] CTRL_KEEP = 32'h0000_F98F;

  // Bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // One transfer; request held until pready is seen at a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= (a == `DPSM_CTRL_OFS) ? (d & CTRL_KEEP) : d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata; // Stale data scrambled so nothing leans on it
    @(posedge clk_sys);
  endtask : xfer

  // With a braking loop, motion is stopped through the halt bit only
  task automatic halt_stop(input logic [15:0] w, output logic [31:0] q, output logic e);
    xfer(1'b1, `DPSM_CTRL_OFS, {16'h0000, w | 16'h0100}, q, e);
  endtask : halt_stop
endmodule : dpsm_plc
`default_nettype wire

// File: sim/drive_profile_state_machine_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "dpsm_map.svh"
module drive_profile_state_machine_tb_top;
  logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, rerr, fq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] w;
  dpsm_pkg::dpsm_pins_t pins;
  dpsm_pkg::dpsm_drive_t drive;
  dpsm_pkg::dpsm_state_t state;
  int miscompares = 0;
  int num_checks = 0;
  int seed = 30;

  // ----------------------------------------
  // Device and bus master
  // ----------------------------------------
  dpsm_top u_dut (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pins_i(pins), .drive_o(drive), .state_o(state));
  dpsm_plc u_plc (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);

  // ----------------------------------------
  // Expectations and checking
  // ----------------------------------------
  // Masked status per state; fault after quick stop sets bit 5
  function automatic logic [31:0] st_code(input dpsm_pkg::dpsm_state_t s);
    case (s)
      dpsm_pkg::ST_SOD: return 32'h0000_0040;
      dpsm_pkg::ST_READY: return 32'h0000_0021;
      dpsm_pkg::ST_SWON: return 32'h0000_0023;
      dpsm_pkg::ST_OPEN: return 32'h0000_0027;
      dpsm_pkg::ST_QSA: return 32'h0000_0007;
      dpsm_pkg::ST_FRA: return 32'h0000_000F;
      dpsm_pkg::ST_FAULT: return fq ? 32'h0000_0028 : 32'h0000_0008;
      default: return 32'h0000_0000;
    endcase
  endfunction : st_code

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic rd(input logic [11:0] a);
    u_plc.xfer(1'b0, a, 32'h0000_0000, rdat, rerr);
  endtask : rd

  task automatic expect_st(input dpsm_pkg::dpsm_state_t s);
    rd(`DPSM_STAT_OFS);
    check(rdat & 32'h0000_006F, st_code(s));
    check({29'h0, state}, {29'h0, s});
  endtask : expect_st

  task automatic cmd(input logic [15:0] word, input dpsm_pkg::dpsm_state_t s);
    u_plc.xfer(1'b1, `DPSM_CTRL_OFS, {16'h0000, word}, rdat, rerr);
    expect_st(s);
  endtask : cmd

  task automatic cfg(input logic [31:0] v);
    u_plc.xfer(1'b1, `DPSM_CFG_OFS, v, rdat, rerr);
  endtask : cfg

  // Pins pass two sync flops before the state logic sees them
  task automatic pin_wait;
    repeat (4) @(posedge clk_sys);
  endtask : pin_wait

  task automatic go_open;
    cmd(16'h0006, dpsm_pkg::ST_READY);
    cmd(16'h0007, dpsm_pkg::ST_SWON);
    cmd(16'h000F, dpsm_pkg::ST_OPEN);
  endtask : go_open

  task automatic do_fault;
    pins.fault <= 1'b1;
    pin_wait();
    expect_st(dpsm_pkg::ST_FRA);
    pins.fault_done <= 1'b1;
    pin_wait();
    expect_st(dpsm_pkg::ST_FAULT);
    {pins.fault, pins.fault_done} <= 2'b00;
    pin_wait();
  endtask : do_fault

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // A hang counts as a failure and ends the run
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    conclude();
  end

  initial begin
    arst_n = 1'b0;
    fq = 1'b0;
    pins = '0;
    pins.line_ok = 1'b1;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rd(`DPSM_CFG_OFS);
    check(rdat, 32'h0001_0020);
    rd(12'h00C);
    check({rdat[30:0], rerr}, 32'h0000_0001);
    expect_st(dpsm_pkg::ST_SOD);
    u_plc.xfer(1'b1, `DPSM_STAT_OFS, 32'h0000_FFFF, rdat, rerr);
    cmd(16'h0007, dpsm_pkg::ST_SOD);
    // Random don't-care bits around shutdown and disable voltage
    for (int i = 0; i < 8; i++) begin
      w = 16'($random(seed));
      cmd((w & 16'hF988) | 16'h0006, dpsm_pkg::ST_READY);
      cmd(w & 16'hF98D, dpsm_pkg::ST_SOD);
    end
    cmd(16'h0006, dpsm_pkg::ST_READY);
    cmd(16'h0002, dpsm_pkg::ST_SOD);
    go_open();
    cmd(16'h0007, dpsm_pkg::ST_SWON);
    cmd(16'h0002, dpsm_pkg::ST_SOD);
    go_open();
    cmd(16'h0002, dpsm_pkg::ST_QSA);
    check({31'h0, drive.fast_ramp}, 32'h0000_0001);
    pins.stop_done <= 1'b1;
    pin_wait();
    expect_st(dpsm_pkg::ST_SOD);
    pins.stop_done <= 1'b0;
    go_open();
    u_plc.halt_stop(16'h000F, rdat, rerr);
    expect_st(dpsm_pkg::ST_OPEN);
    check({31'h0, drive.torque_en}, 32'h0000_0000);
    check({31'h0, drive.power_en}, 32'h0000_0000);
    check({31'h0, drive.fast_ramp}, 32'h0000_0001);
    cfg(32'h0001_0024);
    cmd(16'h000F, dpsm_pkg::ST_OPEN);
    u_plc.halt_stop(16'h000F, rdat, rerr);
    expect_st(dpsm_pkg::ST_OPEN);
    check({31'h0, drive.torque_en}, 32'h0000_0001);
    // Remaining stop types while the halt bit stays set
    cfg(32'h0001_0027);
    expect_st(dpsm_pkg::ST_OPEN);
    check({31'h0, drive.dc_inject}, 32'h0000_0001);
    check({31'h0, drive.power_en}, 32'h0000_0001);
    cfg(32'h0001_0026);
    expect_st(dpsm_pkg::ST_OPEN);
    check({31'h0, drive.freewheel}, 32'h0000_0001);
    cfg(32'h0001_0025);
    expect_st(dpsm_pkg::ST_OPEN);
    check({31'h0, drive.ramp_stop}, 32'h0000_0001);
    pins.term_fast <= 1'b1;
    pin_wait();
    expect_st(dpsm_pkg::ST_SWON);
    check({31'h0, drive.contactor}, 32'h0000_0001);
    check({31'h0, drive.power_en}, 32'h0000_0000);
    cmd(16'h0000, dpsm_pkg::ST_SOD);
    pins.term_fast <= 1'b0;
    go_open();
    pins.term_free <= 1'b1;
    pin_wait();
    expect_st(dpsm_pkg::ST_SOD);
    cmd(16'h0000, dpsm_pkg::ST_SOD);
    pins.term_free <= 1'b0;
    // Fast stop on bit 12, freewheel on bit 13
    cfg(32'h0001_3224);
    go_open();
    cmd(16'h100F, dpsm_pkg::ST_SWON);
    cmd(16'h0000, dpsm_pkg::ST_SOD);
    go_open();
    cmd(16'h200F, dpsm_pkg::ST_SOD);
    {pins.remote, pins.target, pins.limit, pins.warning} <= 4'hF;
    cmd(16'h0006, dpsm_pkg::ST_READY);
    cmd(16'h0007, dpsm_pkg::ST_SWON);
    cmd(16'h080F, dpsm_pkg::ST_OPEN);
    check(rdat, 32'h0000_8EB7);
    {pins.remote, pins.target, pins.limit, pins.warning} <= 4'h0;
    cfg(32'h0001_0028);
    cmd(16'h0000, dpsm_pkg::ST_SOD);
    go_open();
    cmd(16'h0007, dpsm_pkg::ST_OPEN);
    check({31'h0, drive.ramp_stop}, 32'h0000_0001);
    pins.stop_done <= 1'b1;
    pin_wait();
    expect_st(dpsm_pkg::ST_SWON);
    pins.stop_done <= 1'b0;
    cfg(32'h0001_0060);
    cmd(16'h0000, dpsm_pkg::ST_SOD);
    go_open();
    cmd(16'h0002, dpsm_pkg::ST_QSA);
    pins.stop_done <= 1'b1;
    pin_wait();
    expect_st(dpsm_pkg::ST_QSA);
    pins.stop_done <= 1'b0;
    fq = 1'b1;
    do_fault();
    cmd(16'h0082, dpsm_pkg::ST_SOD);
    fq = 1'b0;
    do_fault();
    cmd(16'h0082, dpsm_pkg::ST_FAULT);
    cmd(16'h0000, dpsm_pkg::ST_FAULT);
    cmd(16'h0080, dpsm_pkg::ST_SOD);
    conclude();
  end
endmodule : drive_profile_state_machine_tb_top
`default_nettype wire
